// >>> pkg/pmoc_consts.vh
// Constants for the power mode and oscillator control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PMOC_CONSTS_VH
`define PMOC_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define PMOC_IDX_POWER_CONTROL 10'h087
`define PMOC_IDX_EXT_OSC_CONTROL 10'h0b1
`define PMOC_IDX_INT_OSC_CONTROL 10'h0b2
`define PMOC_IDX_INT_OSC_TRIM 10'h0b3
`define PMOC_ADDR_W 10

// Reset values.
`define PMOC_RST_POWER_CONTROL 8'h00
`define PMOC_RST_EXT_OSC_CONTROL 8'h00
`define PMOC_RST_INT_OSC_CONTROL 8'h07
`define PMOC_RST_INT_OSC_TRIM 7'h00

// Power control fields.
`define PMOC_PC_IDLE_BIT 0
`define PMOC_PC_STOP_BIT 1
`define PMOC_PC_FLAGS_LSB 2
`define PMOC_PC_FLAGS_MSB 7

// External oscillator control fields.
`define PMOC_XO_VALID_BIT 7
`define PMOC_XO_MODE_MSB 6
`define PMOC_XO_MODE_LSB 4
`define PMOC_XO_RANGE_MSB 2
`define PMOC_XO_RANGE_LSB 0

// External oscillator modes.
`define PMOC_XMODE_CMOS 3'h2
`define PMOC_XMODE_CMOS_DIV2 3'h3
`define PMOC_XMODE_RC_DIV2 3'h4
`define PMOC_XMODE_CAP_DIV2 3'h5
`define PMOC_XMODE_XTAL 3'h6
`define PMOC_XMODE_XTAL_DIV2 3'h7

// Internal oscillator control fields.
`define PMOC_IO_DIV_MSB 1
`define PMOC_IO_DIV_LSB 0
`define PMOC_IO_EN_BIT 2
`define PMOC_IO_SRC_EXT_BIT 3

// Program fetch address after any reset.
`define PMOC_RESET_VECTOR 16'h0000

`endif

// >>> design/pmoc_div.v
// Programmable tick divider: one output pulse per PERIOD+1 input enables.
// Assumes one clock; the enable and period are synchronous to it.
module pmoc_div #(
   parameter W = 7
) (
   input wire clk,
   input wire rst,
   input wire en,
   input wire [W-1:0] period,
   output reg tick
);
   reg [W-1:0] cnt_reg;

   // Count down on each enable and reload on wrap, so a new period takes
   // effect at the next wrap without a glitch in the tick spacing.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= {W{1'b0}};
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (en) begin
            if (cnt_reg == {W{1'b0}}) begin
               cnt_reg <= period;
               tick <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// >>> design/pmoc_top.v
// Power mode and oscillator control with an Avalon-MM register slave.
// Assumes the CPU pulses INSTR_DONE when an instruction completes and that
// reset request inputs and EXT_OSC_TICK are synchronous to MCLK.
//
// Summary of operation
// - Idle is entered only after the writing instruction completes.
// - Idle keeps state; timer, interrupt, serial, analog clocks keep running.
// - An enabled interrupt in idle clears idle and resumes the CPU.
// - A reset ending idle runs normal reset, fetching from address 0x0000.
// - Watchdog keeps running in idle and its reset ends idle.
// - Stop halts internal oscillator, CPU, digital peripherals; external kept.
// - Stop halts system clock, interrupts, timers; missing clock detector runs.
// - Only a reset ends stop, then execution starts at 0x0000.
// - Missing clock detector reset ends stop; disable it for long stops.
// - Six upper power control bits are plain software flags.
// - With oscillators turned off, only a reset restarts operation.
// - System clock from external, internal, or scaled internal oscillator.
// - Any system reset selects the internal oscillator.
// - Internal divider selects 1, 2, 4 or 8 and resets to 8.
// - Internal oscillator period is set by a writable trim register.
// - Crystal valid reads 1 only in crystal modes when running and stable.
//
// The Avalon-MM slave port was chosen for this implementation.
`include "pmoc_consts.vh"

module pmoc_top #(
   parameter TRIM_W = 7
) (
   input wire MCLK,
   input wire RST,
   input wire [`PMOC_ADDR_W+1:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   input wire INSTR_DONE,
   input wire IRQ_PENDING,
   input wire WDT_RESET_REQ,
   input wire MCD_RESET_REQ,
   input wire EXT_RESET_REQ,
   input wire EXT_OSC_TICK,
   input wire XTAL_STABLE,
   output reg CPU_CLK_EN,
   output reg PERIPH_CLK_EN,
   output reg MCD_CLK_EN,
   output reg INT_OSC_RUN,
   output reg SYSCLK_TICK,
   output reg CORE_RESET,
   output reg [15:0] FETCH_ADDR,
   output reg [2:0] EXT_OSC_MODE,
   output reg [2:0] EXT_OSC_RANGE,
   output reg [TRIM_W-1:0] INT_OSC_TRIM
);
   // Power states, one-hot.
   localparam [2:0] ST_RUN = 3'b001;
   localparam [2:0] ST_IDLE = 3'b010;
   localparam [2:0] ST_STOP = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [5:0] flags_reg;
   reg idle_arm_reg;
   reg stop_arm_reg;
   reg [2:0] xmode_reg;
   reg [2:0] xrange_reg;
   reg [1:0] div_sel_reg;
   reg int_en_reg;
   reg src_ext_reg;
   reg [TRIM_W-1:0] trim_reg;
   reg [31:0] rdata_next;
   reg xdiv2;
   reg sys_tick_next;

   wire [`PMOC_ADDR_W-1:0] idx;
   wire req;
   wire wr_now;
   wire lane0;
   wire reset_evt;
   wire osc_tick;
   wire div_tick;
   wire xdiv_tick;
   wire xtal_mode;
   wire [2:0] div_period;
   wire osc_on;

   assign idx = AVS_ADDRESS[`PMOC_ADDR_W+1:2];
   assign req = AVS_READ | AVS_WRITE;
   // A write lands only at the edge where waitrequest is seen low.
   assign wr_now = AVS_WRITE & ~AVS_WAITREQUEST;
   assign lane0 = AVS_BYTEENABLE[0];
   assign reset_evt = WDT_RESET_REQ | MCD_RESET_REQ | EXT_RESET_REQ;
   assign xtal_mode = (xmode_reg == `PMOC_XMODE_XTAL) |
                      (xmode_reg == `PMOC_XMODE_XTAL_DIV2);
   // divide by 1, 2, 4 or 8.
   assign div_period = (3'h1 << div_sel_reg) - 3'h1;
   assign osc_on = int_en_reg & (state_reg != ST_STOP);

   pmoc_div #(.W(TRIM_W)) u_osc (
      .clk(MCLK),
      .rst(RST),
      .en(osc_on),
      .period(trim_reg),
      .tick(osc_tick)
   );

   // The scaler runs from oscillator ticks, so it stops with the oscillator.
   pmoc_div #(.W(3)) u_scale (
      .clk(MCLK),
      .rst(RST),
      .en(osc_tick),
      .period(div_period),
      .tick(div_tick)
   );

   pmoc_div #(.W(1)) u_xdiv (
      .clk(MCLK),
      .rst(RST),
      .en(EXT_OSC_TICK),
      .period(xdiv2),
      .tick(xdiv_tick)
   );

   // pick the divide by two stage from the external mode.
   always @* begin
      case (xmode_reg)
         `PMOC_XMODE_CMOS_DIV2: xdiv2 = 1'b1;
         `PMOC_XMODE_RC_DIV2: xdiv2 = 1'b1;
         `PMOC_XMODE_CAP_DIV2: xdiv2 = 1'b1;
         `PMOC_XMODE_XTAL_DIV2: xdiv2 = 1'b1;
         default: xdiv2 = 1'b0;
      endcase
   end

   // source select for the system clock tick.
   // no system clock tick in stop.
   always @* begin
      sys_tick_next = 1'b0;
      if (state_reg != ST_STOP) begin
         if (src_ext_reg) begin
            sys_tick_next = xdiv_tick & (xmode_reg >= `PMOC_XMODE_CMOS);
         end else begin
            sys_tick_next = div_tick;
         end
      end
   end

   // Power state sequencing; a reset request beats every other cause.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            // stop waits for the writing instruction.
            if (stop_arm_reg & INSTR_DONE) begin
               state_next = ST_STOP;
            // idle waits for the writing instruction.
            end else if (idle_arm_reg & INSTR_DONE) begin
               state_next = ST_IDLE;
            // internal oscillator off while it clocks the core.
            end else if (~int_en_reg & ~src_ext_reg) begin
               state_next = ST_STOP;
            end
         end
         ST_IDLE: begin
            // an enabled interrupt wakes the CPU.
            if (IRQ_PENDING) begin
               state_next = ST_RUN;
            end
         end
         ST_STOP: begin
            state_next = ST_STOP;
         end
         default: state_next = ST_RUN;
      endcase
      // reset ends idle as well as stop.
      if (reset_evt) begin
         state_next = ST_RUN;
      end
   end

   // Read mux; unmapped indices read as zero.
   always @* begin
      rdata_next = 32'h00000000;
      if (idx == `PMOC_IDX_POWER_CONTROL) begin
         rdata_next[7:0] = {flags_reg, 2'b00};
      end else if (idx == `PMOC_IDX_EXT_OSC_CONTROL) begin
         rdata_next[`PMOC_XO_VALID_BIT] = xtal_mode & XTAL_STABLE;
         rdata_next[`PMOC_XO_MODE_MSB:`PMOC_XO_MODE_LSB] = xmode_reg;
         rdata_next[`PMOC_XO_RANGE_MSB:`PMOC_XO_RANGE_LSB] = xrange_reg;
      end else if (idx == `PMOC_IDX_INT_OSC_CONTROL) begin
         rdata_next[`PMOC_IO_SRC_EXT_BIT] = src_ext_reg;
         rdata_next[`PMOC_IO_EN_BIT] = int_en_reg;
         rdata_next[`PMOC_IO_DIV_MSB:`PMOC_IO_DIV_LSB] = div_sel_reg;
      end else if (idx == `PMOC_IDX_INT_OSC_TRIM) begin
         rdata_next[TRIM_W-1:0] = trim_reg;
      end
   end

   // Bus handshake: one wait cycle, then a single low cycle per request.
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h00000000;
      end else begin
         AVS_WAITREQUEST <= 1'b1;
         if (req & AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA <= rdata_next;
         end
      end
   end

   // Registers and power state; internal resets restore defaults too.
   // idle entry clears only the idle and stop arm bits; only the CPU clock stops.
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_RUN;
         flags_reg <= 6'h00;
         idle_arm_reg <= 1'b0;
         stop_arm_reg <= 1'b0;
         xmode_reg <= 3'h0;
         xrange_reg <= 3'h0;
         div_sel_reg <= 2'h3;
         int_en_reg <= 1'b1;
         src_ext_reg <= 1'b0;
         trim_reg <= `PMOC_RST_INT_OSC_TRIM;
      end else if (reset_evt) begin
         state_reg <= ST_RUN;
         flags_reg <= 6'h00;
         idle_arm_reg <= 1'b0;
         stop_arm_reg <= 1'b0;
         xmode_reg <= 3'h0;
         xrange_reg <= 3'h0;
         div_sel_reg <= 2'h3;
         int_en_reg <= 1'b1;
         src_ext_reg <= 1'b0;
         trim_reg <= `PMOC_RST_INT_OSC_TRIM;
      end else begin
         state_reg <= state_next;
         if (state_next != ST_RUN) begin
            idle_arm_reg <= 1'b0;
            stop_arm_reg <= 1'b0;
         end
         if (wr_now & lane0) begin
            if (idx == `PMOC_IDX_POWER_CONTROL) begin
               flags_reg <= AVS_WRITEDATA[`PMOC_PC_FLAGS_MSB:
                                          `PMOC_PC_FLAGS_LSB];
               idle_arm_reg <= AVS_WRITEDATA[`PMOC_PC_IDLE_BIT];
               stop_arm_reg <= AVS_WRITEDATA[`PMOC_PC_STOP_BIT];
            end else if (idx == `PMOC_IDX_EXT_OSC_CONTROL) begin
               xmode_reg <= AVS_WRITEDATA[`PMOC_XO_MODE_MSB:
                                          `PMOC_XO_MODE_LSB];
               xrange_reg <= AVS_WRITEDATA[`PMOC_XO_RANGE_MSB:
                                           `PMOC_XO_RANGE_LSB];
            end else if (idx == `PMOC_IDX_INT_OSC_CONTROL) begin
               div_sel_reg <= AVS_WRITEDATA[`PMOC_IO_DIV_MSB:
                                            `PMOC_IO_DIV_LSB];
               int_en_reg <= AVS_WRITEDATA[`PMOC_IO_EN_BIT];
               src_ext_reg <= AVS_WRITEDATA[`PMOC_IO_SRC_EXT_BIT];
            end else if (idx == `PMOC_IDX_INT_OSC_TRIM) begin
               trim_reg <= AVS_WRITEDATA[TRIM_W-1:0];
            end
         end
      end
   end

   // Registered outputs to the rest of the chip.
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         CPU_CLK_EN <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         MCD_CLK_EN <= 1'b1;
         INT_OSC_RUN <= 1'b1;
         SYSCLK_TICK <= 1'b0;
         CORE_RESET <= 1'b1;
         FETCH_ADDR <= `PMOC_RESET_VECTOR;
         EXT_OSC_MODE <= 3'h0;
         EXT_OSC_RANGE <= 3'h0;
         INT_OSC_TRIM <= `PMOC_RST_INT_OSC_TRIM;
      end else begin
         CPU_CLK_EN <= (state_next == ST_RUN);
         // watchdog and peripherals stay clocked in idle.
         PERIPH_CLK_EN <= (state_next != ST_STOP);
         // the detector keeps its own clock in stop.
         MCD_CLK_EN <= 1'b1;
         INT_OSC_RUN <= osc_on;
         SYSCLK_TICK <= sys_tick_next;
         // reset pulse restarts fetch at the reset vector.
         CORE_RESET <= reset_evt;
         FETCH_ADDR <= `PMOC_RESET_VECTOR;
         // the external circuit keeps its setting through stop.
         EXT_OSC_MODE <= xmode_reg;
         EXT_OSC_RANGE <= xrange_reg;
         INT_OSC_TRIM <= trim_reg;
      end
   end
endmodule

// >>> verif/pmoc_monitor.sv
// Checker for the power mode and oscillator control block.
// Assumes it is bound to pmoc_top and sees only that module's ports.
module pmoc_monitor (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic INSTR_DONE,
   input wire logic IRQ_PENDING,
   input wire logic WDT_RESET_REQ,
   input wire logic MCD_RESET_REQ,
   input wire logic EXT_RESET_REQ,
   input wire logic XTAL_STABLE,
   input wire logic CPU_CLK_EN,
   input wire logic PERIPH_CLK_EN,
   input wire logic INT_OSC_RUN,
   input wire logic SYSCLK_TICK,
   input wire logic CORE_RESET,
   input wire logic [15:0] FETCH_ADDR,
   input wire logic [2:0] EXT_OSC_MODE
);
   // Any reset request overrides whatever the block was doing.
   wire req = WDT_RESET_REQ | MCD_RESET_REQ | EXT_RESET_REQ;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // A read of one register index, taken by the slave.
   sequence s_rd(idx);
      AVS_READ && AVS_WAITREQUEST && !req && AVS_ADDRESS[11:2] == idx;
   endsequence
   // Stop entry: the instruction completes, then peripherals halt.
   sequence s_stop_entry;
      INSTR_DONE ##1 $fell(PERIPH_CLK_EN) && !req;
   endsequence
   chk_bus_answer:
   assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !req
      |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer is not a single cycle after the request");
   chk_pc_zero:
   assert property (s_rd(10'h087) |=> AVS_READDATA[1:0] == 2'h0)
      else $error("mode select bits read back nonzero");
   chk_xtal_flag:
   assert property (s_rd(10'h0b1) |=> AVS_READDATA[7] == ($past(XTAL_STABLE)
      && $past(EXT_OSC_MODE[2]) && $past(EXT_OSC_MODE[1])))
      else $error("crystal valid flag wrong");
   chk_idle_entry:
   assert property ($fell(CPU_CLK_EN) && PERIPH_CLK_EN |-> $past(INSTR_DONE))
      else $error("cpu halted before the instruction completed");
   chk_idle_periph:
   assert property ($fell(CPU_CLK_EN) && PERIPH_CLK_EN && !req
      |=> PERIPH_CLK_EN && INT_OSC_RUN)
      else $error("peripheral clocks stopped in idle");
   chk_idle_wake:
   assert property (!CPU_CLK_EN && PERIPH_CLK_EN && $rose(IRQ_PENDING)
      |=> CPU_CLK_EN)
      else $error("interrupt did not end idle");
   chk_stop_osc:
   assert property (s_stop_entry |-> !CPU_CLK_EN ##1 !INT_OSC_RUN)
      else $error("stop left the cpu or internal oscillator running");
   chk_stop_hold:
   assert property (!PERIPH_CLK_EN && !req |=> !PERIPH_CLK_EN && !CPU_CLK_EN)
      else $error("stop ended without a reset");
   chk_stop_noclk:
   assert property ((!PERIPH_CLK_EN)[*5] |-> !SYSCLK_TICK && !INT_OSC_RUN)
      else $error("system clock ticked in stop");
   chk_req_reset:
   assert property (req |=> CORE_RESET && CPU_CLK_EN && FETCH_ADDR == 16'h0000)
      else $error("reset request did not restart the core");
   chk_mcd_reset:
   // The oscillator run flag follows the power state one cycle later.
   assert property (MCD_RESET_REQ |=> PERIPH_CLK_EN ##1 INT_OSC_RUN)
      else $error("missing clock reset did not end stop");
endmodule

// >>> verif/pmoc_xosc_model.sv
// External oscillator source: one tick every period clocks while running.
// Assumes the bench drives run and period synchronously to clk.
module pmoc_xosc_model #(
   parameter SETTLE = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [7:0] period,
   output logic tick,
   output logic stable
);
   int cnt_reg;
   int seen_reg;
   // A stopped source gives no ticks and loses its settled state at once.
   always @(posedge clk or posedge rst) begin
      if (rst || !run) begin
         cnt_reg <= 0;
         seen_reg <= 0;
         tick <= 1'h0;
         stable <= 1'h0;
      end else begin
         tick <= (cnt_reg == 0);
         cnt_reg <= (cnt_reg + 1 >= period) ? 0 : cnt_reg + 1;
         if (cnt_reg == 0 && seen_reg < SETTLE)
            seen_reg <= seen_reg + 1;
         stable <= (seen_reg >= SETTLE);
      end
   end
endmodule

// >>> verif/tb_power_mode_and_oscillator_control.sv
// Self-checking bench for the power mode and oscillator control block.
// Assumes pmoc_top with the external oscillator model beside it.
module tb_power_mode_and_oscillator_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic MCLK = 1'h0, RST = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
   logic [11:0] AVS_ADDRESS = 12'h000;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0] AVS_BYTEENABLE = 4'h1;
   logic INSTR_DONE = 1'h0, IRQ_PENDING = 1'h0, WDT_RESET_REQ = 1'h0;
   logic MCD_RESET_REQ = 1'h0, EXT_RESET_REQ = 1'h0, x_run = 1'h1;
   logic [7:0] x_per = 8'h03;
   logic [31:0] rd;
   wire [31:0] AVS_READDATA;
   wire AVS_WAITREQUEST, EXT_OSC_TICK, XTAL_STABLE, CPU_CLK_EN;
   wire PERIPH_CLK_EN, MCD_CLK_EN, INT_OSC_RUN, SYSCLK_TICK, CORE_RESET;
   wire [15:0] FETCH_ADDR;
   wire [2:0] EXT_OSC_MODE, EXT_OSC_RANGE;
   wire [6:0] INT_OSC_TRIM;
   int errors = 0, compares = 0, cyc = 0;
   pmoc_top #(.TRIM_W(7)) u_dut (.MCLK(MCLK), .RST(RST),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .INSTR_DONE(INSTR_DONE), .IRQ_PENDING(IRQ_PENDING),
      .WDT_RESET_REQ(WDT_RESET_REQ), .MCD_RESET_REQ(MCD_RESET_REQ),
      .EXT_RESET_REQ(EXT_RESET_REQ), .EXT_OSC_TICK(EXT_OSC_TICK),
      .XTAL_STABLE(XTAL_STABLE), .CPU_CLK_EN(CPU_CLK_EN),
      .PERIPH_CLK_EN(PERIPH_CLK_EN), .MCD_CLK_EN(MCD_CLK_EN),
      .INT_OSC_RUN(INT_OSC_RUN), .SYSCLK_TICK(SYSCLK_TICK),
      .CORE_RESET(CORE_RESET), .FETCH_ADDR(FETCH_ADDR),
      .EXT_OSC_MODE(EXT_OSC_MODE), .EXT_OSC_RANGE(EXT_OSC_RANGE),
      .INT_OSC_TRIM(INT_OSC_TRIM));
   pmoc_xosc_model #(.SETTLE(4)) u_xosc (.clk(MCLK), .rst(RST), .run(x_run),
      .period(x_per), .tick(EXT_OSC_TICK), .stable(XTAL_STABLE));
   // Free-running 50 MHz system clock.
   initial begin
      forever #10 MCLK = ~MCLK;
   end
   // Cuts a hung run short; the tests need under two thousand cycles.
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus cycle; the request is held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [9:0] idx,
      input logic [7:0] d, input logic [3:0] be);
      @(posedge MCLK);
      AVS_ADDRESS <= {idx, 2'h0};
      AVS_WRITEDATA <= {24'h0, d};
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      // Only the bench timeout ends a wait that never gets an answer.
      do begin
         @(posedge MCLK);
      end while (AVS_WAITREQUEST !== 1'h0);
      rd = AVS_READDATA;
      AVS_READ <= 1'h0;
      AVS_WRITE <= 1'h0;
      chk("bus answer", 1'h0, AVS_WAITREQUEST);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus(1'h1, idx, d, 4'h1);
   endtask
   task automatic rc(input string nm, input logic [9:0] idx, logic [7:0] e);
      bus(1'h0, idx, 8'h00, 4'h1);
      chk(nm, {24'h0, e}, rd);
   endtask
   // Cycles up to the next system tick; zero when none comes.
   task automatic gap(output int g);
      g = 0;
      do begin
         @(posedge MCLK);
         g++;
      end while (SYSCLK_TICK !== 1'h1 && g < 64);
      if (g == 64)
         g = 0;
   endtask
   // The first two gaps may straddle a setting change, so the third counts.
   task automatic period(input logic [31:0] e);
      int g;
      gap(g);
      gap(g);
      gap(g);
      chk("tick period", e, g);
   endtask
   // Pulses one of: instruction done, watchdog, detector, external reset.
   task automatic pulse(input int k);
      @(posedge MCLK);
      {EXT_RESET_REQ, MCD_RESET_REQ, WDT_RESET_REQ, INSTR_DONE} <= 4'h1 << k;
      @(posedge MCLK);
      {EXT_RESET_REQ, MCD_RESET_REQ, WDT_RESET_REQ, INSTR_DONE} <= 4'h0;
      repeat (2) @(posedge MCLK);
   endtask
   task automatic results;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence: registers, clock paths, idle, then stop.
   initial begin
      repeat (6) @(posedge MCLK);
      RST <= 1'h0;
      rc("power ctl", 10'h087, 8'h00);
      rc("ext osc ctl", 10'h0b1, 8'h00);
      rc("int osc ctl", 10'h0b2, 8'h07);
      rc("trim", 10'h0b3, 8'h00);
      rc("unmapped", 10'h000, 8'h00);
      period(8);
      wr(10'h0b3, 8'h02);
      for (int d = 0; d < 4; d++) begin
         wr(10'h0b2, 8'h04 | d[7:0]);
         period(3 << d);
      end
      chk("trim out", 8'h02, INT_OSC_TRIM);
      wr(10'h087, 8'ha8);
      rc("flags", 10'h087, 8'ha8);
      bus(1'h1, 10'h087, 8'h54, 4'h0);
      wr(10'h000, 8'hff);
      rc("masked write", 10'h087, 8'ha8);
      wr(10'h0b2, 8'h0c);
      for (int m = 0; m < 8; m++) begin
         wr(10'h0b1, {1'h0, m[2:0], 4'h5});
         rc("ext mode", 10'h0b1, {m[2] & m[1], m[2:0], 4'h5});
         period(m < 2 ? 0 : (m == 2 || m == 6) ? 3 : 6);
      end
      x_run <= 1'h0;
      rc("not stable", 10'h0b1, 8'h75);
      x_per <= 8'h09;
      x_run <= 1'h1;
      period(18);
      rc("stable", 10'h0b1, 8'hf5);
      wr(10'h0b2, 8'h04);
      wr(10'h087, 8'ha9);
      repeat (3) @(posedge MCLK);
      chk("cpu before done", 1'h1, CPU_CLK_EN);
      pulse(0);
      chk("idle cpu", 1'h0, CPU_CLK_EN);
      chk("idle periph", 1'h1, PERIPH_CLK_EN);
      period(3);
      rc("idle flags", 10'h087, 8'ha8);
      IRQ_PENDING <= 1'h1;
      repeat (2) @(posedge MCLK);
      chk("irq wake", 1'h1, CPU_CLK_EN);
      IRQ_PENDING <= 1'h0;
      wr(10'h087, 8'h01);
      pulse(0);
      chk("idle again", 1'h0, CPU_CLK_EN);
      pulse(1);
      chk("watchdog wake", 1'h1, CPU_CLK_EN);
      chk("fetch", 16'h0000, FETCH_ADDR);
      rc("pc after reset", 10'h087, 8'h00);
      rc("ioc after reset", 10'h0b2, 8'h07);
      for (int k = 1; k < 4; k++) begin
         wr(10'h0b1, 8'h65);
         wr(10'h087, 8'h02);
         pulse(0);
         IRQ_PENDING <= 1'h1;
         period(0);
         chk("stop cpu", 1'h0, CPU_CLK_EN);
         chk("stop periph", 1'h0, PERIPH_CLK_EN);
         chk("stop osc", 1'h0, INT_OSC_RUN);
         chk("ext kept", 3'h6, EXT_OSC_MODE);
         chk("ext range kept", 3'h5, EXT_OSC_RANGE);
         chk("detector clock", 1'h1, MCD_CLK_EN);
         IRQ_PENDING <= 1'h0;
         pulse(k);
         chk("stop ended", 1'h1, PERIPH_CLK_EN);
      end
      // Turning off the oscillator that clocks the core needs a reset.
      wr(10'h0b2, 8'h03);
      repeat (2) @(posedge MCLK);
      chk("osc off cpu", 1'h0, CPU_CLK_EN);
      chk("osc off periph", 1'h0, PERIPH_CLK_EN);
      pulse(3);
      chk("osc off restart", 1'h1, PERIPH_CLK_EN);
      rc("osc off reset", 10'h0b2, 8'h07);
      results();
   end
endmodule
bind pmoc_top pmoc_monitor u_mon (.MCLK(MCLK), .RST(RST),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .INSTR_DONE(INSTR_DONE), .IRQ_PENDING(IRQ_PENDING),
   .WDT_RESET_REQ(WDT_RESET_REQ), .MCD_RESET_REQ(MCD_RESET_REQ),
   .EXT_RESET_REQ(EXT_RESET_REQ), .XTAL_STABLE(XTAL_STABLE),
   .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
   .INT_OSC_RUN(INT_OSC_RUN), .SYSCLK_TICK(SYSCLK_TICK),
   .CORE_RESET(CORE_RESET), .FETCH_ADDR(FETCH_ADDR),
   .EXT_OSC_MODE(EXT_OSC_MODE));
